// >>> csr_pkg.sv
`default_nettype none
package csr_pkg;
  // Register byte offsets
  localparam logic [15:0] PWR_CTRL_OFS   = 16'h0114;
  localparam logic [15:0] BUS_CTRL_OFS   = 16'h0116;
  localparam logic [15:0] INIT_STAT_OFS  = 16'h0136;
  localparam logic [15:0] TXBID_STAT_OFS = 16'h0138;
  // Fixed register-number patterns in bits 5:0
  localparam logic [15:0] PWR_CTRL_ID    = 16'h0015;
  localparam logic [15:0] BUS_CTRL_ID    = 16'h0017;
  localparam logic [15:0] INIT_STAT_ID   = 16'h0016;
  localparam logic [15:0] TXBID_STAT_ID  = 16'h0018;
  // Stored bits and their values after reset
  localparam logic [15:0] PWR_CTRL_MASK  = 16'hf700;
  localparam logic [15:0] BUS_CTRL_MASK  = 16'hbf40;
  localparam logic [15:0] CTRL_RST_BITS  = 16'h0000;
  // Power and pin control fields
  localparam int PWR_RESET_BIT     = 6;
  localparam int PWR_SW_SUSPEND    = 8;
  localparam int PWR_SLEEP_EN      = 9;
  localparam int PWR_STANDBY_SEL   = 10;
  localparam int PWR_GP0_SEL       = 12;
  localparam int PWR_GP1_SEL       = 13;
  localparam int PWR_GP0_DRIVE     = 14;
  localparam int PWR_GP1_DRIVE     = 15;
  // Host bus control fields
  localparam int BUS_RX_DMA_RESET  = 6;
  localparam int BUS_SINGLE_XFER   = 8;
  localparam int BUS_INT_DECODE    = 9;
  localparam int BUS_MEM_MODE_EN   = 10;
  localparam int BUS_BURST_LIMIT   = 11;
  localparam int BUS_READY_DIS     = 12;
  localparam int BUS_RX_BUF_SIZE   = 13;
  localparam int BUS_INT_EN        = 15;
  // Status fields
  localparam int ST_LOW_VOLT       = 6;
  localparam int ST_INIT_DONE      = 7;
  localparam int ST_SI_BUSY        = 8;
  localparam int ST_EE_FOUND       = 9;
  localparam int ST_EE_CSUM_OK     = 10;
  localparam int ST_EXT_DECODE     = 11;
  localparam int ST_EE_SMALL       = 12;
  localparam int TB_BID_ERR        = 7;
  localparam int TB_READY_NOW      = 8;
  // Transmit length limits in bytes
  localparam logic [15:0] TX_MAX_WITH_CRC = 16'h05ea;
  localparam logic [15:0] TX_MAX_ANY      = 16'h05ee;
  localparam logic [15:0] TX_MIN_LEN      = 16'h0003;
  // Receive DMA burst timing and EEPROM strap sampling delay
  localparam int CLK_PERIOD_NS   = 50;
  localparam int BURST_MAX_NS    = 28000;
  localparam int BUS_GAP_NS      = 1300;
  localparam int BURST_CYCLES    = BURST_MAX_NS / CLK_PERIOD_NS;
  localparam int GAP_CYCLES      = (BUS_GAP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int STRAP_DELAY     = 3;

  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_SOFT_SUSP,
    PWR_HW_STANDBY,
    PWR_HW_SUSPEND
  } csr_power_type;
endpackage
`default_nettype wire

// >>> csr_chip_self_bus.sv
`timescale 1ns/1ns
`default_nettype none
module csr_chip_self_bus (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        io_window_write,
  // EEPROM loader and status
  input  wire logic        eeprom_load_valid,
  input  wire logic        eeprom_load_bus,
  input  wire logic [15:0] eeprom_load_data,
  input  wire logic        eeprom_read_done,
  input  wire logic        eeprom_checksum_good,
  input  wire logic        eeprom_small_size,
  input  wire logic        eeprom_chip_select,
  input  wire logic        eeprom_data_in,
  input  wire logic        init_complete,
  input  wire logic        low_voltage_supply,
  input  wire logic        external_decode_present,
  // Power control
  input  wire logic        sleep_pin,
  output logic             chip_reset_req,
  output logic             suspend_reset,
  output logic             txrx_halt,
  output logic             sw_suspend_active,
  output logic             hw_standby_active,
  output logic             hw_suspend_active,
  // General purpose pins
  input  wire logic        link_indicator,
  input  wire logic        bus_activity,
  output logic             link_indicator_pin,
  output logic             bus_activity_pin,
  // ISA decode and wait states
  input  wire logic        chip_select_n,
  input  wire logic [7:0]  sa_high,
  input  wire logic [7:0]  mem_base,
  input  wire logic        io_read_cycle,
  input  wire logic        mem_read_cycle,
  input  wire logic        dma_read_cycle,
  input  wire logic        wait_request,
  output logic             memcs16_n,
  output logic             mem_mode_allowed,
  output logic             ready_out,
  output logic             ready_oe,
  // Receive DMA
  input  wire logic        dma_active,
  output logic             rx_dma_abort,
  output logic             dma_single_transfer,
  output logic             rx_buf_64k,
  output logic             dma_hold_off,
  // Interrupt
  input  wire logic        irq_event,
  output logic             irq_out,
  // Transmit bid
  input  wire logic        tx_cmd_valid,
  input  wire logic [15:0] tx_length,
  input  wire logic        crc_append_inhibit,
  input  wire logic        tx_space_avail,
  output logic             tx_accept,
  output logic             tx_refuse
);

  logic [15:0]          pwr_q;
  logic [15:0]          bus_q;
  logic                 soft_rst_q;
  logic                 bid_err_q;
  logic                 ready_now_q;
  logic                 sleep_meta_q, sleep_sync_q;
  logic                 eed_meta_q, eed_sync_q;
  logic                 cs_meta_q, cs_sync_q;
  logic [7:0]           sa_meta_q, sa_sync_q;
  logic [1:0]           strap_cnt_q;
  logic                 ee_found_q;
  csr_pkg::csr_power_type pwr_state_q;
  csr_pkg::csr_power_type pwr_state_d;
  logic [9:0]           burst_cnt_q;
  logic [4:0]           gap_cnt_q;
  logic [15:0]          rdata_d;
  logic                 wr_pwr, wr_bus, part_rst;
  logic                 too_long, too_short;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  assign wr_pwr    = reg_wr && hit(reg_addr, csr_pkg::PWR_CTRL_OFS);
  assign wr_bus    = reg_wr && hit(reg_addr, csr_pkg::BUS_CTRL_OFS);
  assign part_rst  = (pwr_state_d == csr_pkg::PWR_SOFT_SUSP) &&
                     (pwr_state_q != csr_pkg::PWR_SOFT_SUSP);
  assign too_long  = (tx_length > csr_pkg::TX_MAX_ANY) ||
                     (!crc_append_inhibit &&
                      (tx_length > csr_pkg::TX_MAX_WITH_CRC));
  assign too_short = tx_length < csr_pkg::TX_MIN_LEN;

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_meta_q <= 1'b1;
      sleep_sync_q <= 1'b1;
      eed_meta_q   <= 1'b0;
      eed_sync_q   <= 1'b0;
      cs_meta_q    <= 1'b1;
      cs_sync_q    <= 1'b1;
      sa_meta_q    <= 8'h00;
      sa_sync_q    <= 8'h00;
    end else begin
      sleep_meta_q <= sleep_pin;
      sleep_sync_q <= sleep_meta_q;
      eed_meta_q   <= eeprom_data_in;
      eed_sync_q   <= eed_meta_q;
      cs_meta_q    <= chip_select_n;
      cs_sync_q    <= cs_meta_q;
      sa_meta_q    <= sa_high;
      sa_sync_q    <= sa_meta_q;
    end
  end

  // Act-once chip reset request
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_pwr && reg_wdata[csr_pkg::PWR_RESET_BIT];
    end
  end

  // Power and pin control; survives the suspend partial reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= csr_pkg::CTRL_RST_BITS;
    end else if (soft_rst_q) begin
      pwr_q <= csr_pkg::CTRL_RST_BITS;
    end else if (wr_pwr) begin
      pwr_q <= reg_wdata & csr_pkg::PWR_CTRL_MASK;
    end else if (eeprom_load_valid && !eeprom_load_bus) begin
      pwr_q <= eeprom_load_data & csr_pkg::PWR_CTRL_MASK;
    end else if (io_window_write) begin
      pwr_q[csr_pkg::PWR_SW_SUSPEND] <= 1'b0;
    end
  end

  // Host bus control; cleared by the suspend partial reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_q <= csr_pkg::CTRL_RST_BITS;
    end else if (soft_rst_q || part_rst) begin
      bus_q <= csr_pkg::CTRL_RST_BITS;
    end else if (wr_bus) begin
      bus_q <= reg_wdata & csr_pkg::BUS_CTRL_MASK;
    end else if (eeprom_load_valid && eeprom_load_bus) begin
      bus_q <= eeprom_load_data & csr_pkg::BUS_CTRL_MASK;
    end
  end

  // Low-power mode selection
  always_comb begin
    if (pwr_q[csr_pkg::PWR_SW_SUSPEND]) begin
      pwr_state_d = csr_pkg::PWR_SOFT_SUSP;
    end else if (pwr_q[csr_pkg::PWR_SLEEP_EN] && !sleep_sync_q) begin
      pwr_state_d = pwr_q[csr_pkg::PWR_STANDBY_SEL] ?
                    csr_pkg::PWR_HW_STANDBY :
                    csr_pkg::PWR_HW_SUSPEND;
    end else begin
      pwr_state_d = csr_pkg::PWR_AWAKE;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_state_q       <= csr_pkg::PWR_AWAKE;
      suspend_reset     <= 1'b0;
      txrx_halt         <= 1'b0;
      sw_suspend_active <= 1'b0;
      hw_standby_active <= 1'b0;
      hw_suspend_active <= 1'b0;
    end else begin
      pwr_state_q       <= pwr_state_d;
      suspend_reset     <= part_rst;
      txrx_halt         <= pwr_state_d != csr_pkg::PWR_AWAKE;
      case (pwr_state_d)
        csr_pkg::PWR_SOFT_SUSP: begin
          sw_suspend_active <= 1'b1;
          hw_standby_active <= 1'b0;
          hw_suspend_active <= 1'b0;
        end
        csr_pkg::PWR_HW_STANDBY: begin
          sw_suspend_active <= 1'b0;
          hw_standby_active <= 1'b1;
          hw_suspend_active <= 1'b0;
        end
        csr_pkg::PWR_HW_SUSPEND: begin
          sw_suspend_active <= 1'b0;
          hw_standby_active <= 1'b0;
          hw_suspend_active <= 1'b1;
        end
        default: begin
          sw_suspend_active <= 1'b0;
          hw_standby_active <= 1'b0;
          hw_suspend_active <= 1'b0;
        end
      endcase
    end
  end

  // Reset request and general purpose pins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chip_reset_req     <= 1'b0;
      link_indicator_pin <= 1'b1;
      bus_activity_pin   <= 1'b1;
    end else begin
      chip_reset_req     <= soft_rst_q;
      link_indicator_pin <= pwr_q[csr_pkg::PWR_GP0_SEL] ?
                            !pwr_q[csr_pkg::PWR_GP0_DRIVE] :
                            link_indicator;
      bus_activity_pin   <= pwr_q[csr_pkg::PWR_GP1_SEL] ?
                            !pwr_q[csr_pkg::PWR_GP1_DRIVE] :
                            bus_activity;
    end
  end

  // EEPROM strap caught a few cycles after reset release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_q <= 2'h0;
      ee_found_q  <= 1'b0;
    end else if (strap_cnt_q != 2'(csr_pkg::STRAP_DELAY)) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'(csr_pkg::STRAP_DELAY - 1)) begin
        ee_found_q <= eed_sync_q;
      end
    end
  end

  // ISA decode, wait states, DMA options and interrupt gate
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      memcs16_n           <= 1'b1;
      mem_mode_allowed    <= 1'b0;
      ready_out           <= 1'b0;
      ready_oe            <= 1'b0;
      rx_dma_abort        <= 1'b0;
      dma_single_transfer <= 1'b0;
      rx_buf_64k          <= 1'b0;
      irq_out             <= 1'b0;
    end else begin
      mem_mode_allowed    <= bus_q[csr_pkg::BUS_MEM_MODE_EN];
      memcs16_n           <= !(bus_q[csr_pkg::BUS_MEM_MODE_EN] &&
                               !cs_sync_q &&
                               (!bus_q[csr_pkg::BUS_INT_DECODE] ||
                                (sa_sync_q == mem_base)));
      ready_out           <= 1'b0;
      ready_oe            <= !bus_q[csr_pkg::BUS_READY_DIS] &&
                             wait_request && !dma_read_cycle &&
                             (io_read_cycle || mem_read_cycle);
      rx_dma_abort        <= wr_bus &&
                             reg_wdata[csr_pkg::BUS_RX_DMA_RESET];
      dma_single_transfer <= bus_q[csr_pkg::BUS_SINGLE_XFER];
      rx_buf_64k          <= bus_q[csr_pkg::BUS_RX_BUF_SIZE];
      irq_out             <= bus_q[csr_pkg::BUS_INT_EN] && irq_event;
    end
  end

  // Receive DMA burst limiter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      burst_cnt_q  <= 10'h000;
      gap_cnt_q    <= 5'h00;
      dma_hold_off <= 1'b0;
    end else if (!bus_q[csr_pkg::BUS_BURST_LIMIT] || rx_dma_abort) begin
      burst_cnt_q  <= 10'h000;
      gap_cnt_q    <= 5'h00;
      dma_hold_off <= 1'b0;
    end else if (gap_cnt_q != 5'h00) begin
      gap_cnt_q    <= gap_cnt_q - 5'h01;
      dma_hold_off <= gap_cnt_q != 5'h01;
    end else if (dma_active) begin
      if (burst_cnt_q == 10'(csr_pkg::BURST_CYCLES - 1)) begin
        burst_cnt_q  <= 10'h000;
        gap_cnt_q    <= 5'(csr_pkg::GAP_CYCLES);
        dma_hold_off <= 1'b1;
      end else begin
        burst_cnt_q  <= burst_cnt_q + 10'h001;
      end
    end else begin
      burst_cnt_q <= 10'h000;
    end
  end

  // Transmit bid checks
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bid_err_q   <= 1'b0;
      tx_accept   <= 1'b0;
      tx_refuse   <= 1'b0;
      ready_now_q <= 1'b0;
    end else begin
      tx_accept   <= tx_cmd_valid && !too_long && !too_short &&
                     (pwr_state_q == csr_pkg::PWR_AWAKE);
      tx_refuse   <= tx_cmd_valid && (too_long || too_short);
      ready_now_q <= tx_space_avail && !bid_err_q &&
                     (pwr_state_q == csr_pkg::PWR_AWAKE);
      if (soft_rst_q || part_rst) begin
        bid_err_q <= 1'b0;
      end else if (tx_cmd_valid) begin
        bid_err_q <= too_long;
      end
    end
  end

  // Register read-back
  always_comb begin
    rdata_d = 16'h0000;
    case (reg_addr)
      csr_pkg::PWR_CTRL_OFS:   rdata_d = pwr_q | csr_pkg::PWR_CTRL_ID;
      csr_pkg::BUS_CTRL_OFS:   rdata_d = bus_q | csr_pkg::BUS_CTRL_ID;
      csr_pkg::INIT_STAT_OFS: begin
        rdata_d = csr_pkg::INIT_STAT_ID;
        rdata_d[csr_pkg::ST_LOW_VOLT]   = low_voltage_supply;
        rdata_d[csr_pkg::ST_INIT_DONE]  = init_complete &&
                                          (!ee_found_q ||
                                           eeprom_read_done);
        rdata_d[csr_pkg::ST_SI_BUSY]    = eeprom_chip_select;
        rdata_d[csr_pkg::ST_EE_FOUND]   = ee_found_q;
        rdata_d[csr_pkg::ST_EE_CSUM_OK] = eeprom_checksum_good;
        rdata_d[csr_pkg::ST_EXT_DECODE] = external_decode_present;
        rdata_d[csr_pkg::ST_EE_SMALL]   = eeprom_small_size;
      end
      csr_pkg::TXBID_STAT_OFS: begin
        rdata_d = csr_pkg::TXBID_STAT_ID;
        rdata_d[csr_pkg::TB_BID_ERR]   = bid_err_q;
        rdata_d[csr_pkg::TB_READY_NOW] = ready_now_q;
      end
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence reset_write_s;
    wr_pwr && reg_wdata[csr_pkg::PWR_RESET_BIT];
  endsequence

  sequence reset_effect_s;
    ##1 soft_rst_q ##1 (chip_reset_req && pwr_q == 16'h0000);
  endsequence

  chip_reset_once_a: assert property (
    reset_write_s |-> reset_effect_s)
    else $error("reset bit did not reset the control register");

  suspend_wake_a: assert property (
    io_window_write && !wr_pwr && !soft_rst_q &&
    !(eeprom_load_valid && !eeprom_load_bus)
    |=> !pwr_q[csr_pkg::PWR_SW_SUSPEND])
    else $error("window write did not end software suspend");

  suspend_clears_bus_a: assert property (
    part_rst |=> (bus_q == 16'h0000) ##1 txrx_halt)
    else $error("suspend did not clear bus control");

  sleep_mode_a: assert property (
    pwr_q[csr_pkg::PWR_SLEEP_EN] && !pwr_q[csr_pkg::PWR_SW_SUSPEND] &&
    !sleep_sync_q |=> (hw_standby_active ==
                       $past(pwr_q[csr_pkg::PWR_STANDBY_SEL])))
    else $error("wrong hardware low-power mode");

  gp_pin_drive_a: assert property (
    pwr_q[csr_pkg::PWR_GP0_SEL] |=>
      link_indicator_pin == !$past(pwr_q[csr_pkg::PWR_GP0_DRIVE]))
    else $error("host-driven pin level wrong");

  ready_no_write_a: assert property (
    !io_read_cycle && !mem_read_cycle |=> !ready_oe)
    else $error("ready pulled low outside a read cycle");

  irq_gate_a: assert property (
    !bus_q[csr_pkg::BUS_INT_EN] |=> !irq_out)
    else $error("interrupt raised while disabled");

  burst_cap_a: assert property (
    burst_cnt_q == 10'(csr_pkg::BURST_CYCLES - 1) && dma_active &&
    bus_q[csr_pkg::BUS_BURST_LIMIT] && gap_cnt_q == 5'h00 && !rx_dma_abort
    |=> dma_hold_off [*8])
    else $error("burst limit did not release the bus");

  bid_error_a: assert property (
    tx_cmd_valid && !soft_rst_q && !part_rst &&
    tx_length > csr_pkg::TX_MAX_ANY |=> bid_err_q ##0 !tx_accept)
    else $error("oversize frame not flagged");

  short_refuse_a: assert property (
    tx_cmd_valid && too_short |=> tx_refuse && !tx_accept)
    else $error("short frame not refused");

endmodule
`default_nettype wire

// >>> csr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module csr_host_model (
  // Clock
  input  wire logic        sys_clk,
  // Register port
  output logic      [15:0] reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_wdata,
  output logic             io_window_write,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    io_window_write = 1'b0;
  end
  // Any address can be written; the tests write the two control words and the status word
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
  endtask
  // An I/O write inside the window is how the host wakes the device
  task automatic wake();
    @(posedge sys_clk);
    #1;
    io_window_write = 1'b1;
    @(posedge sys_clk);
    #1;
    io_window_write = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> chip_self_and_bus_control_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module chip_self_and_bus_control_regs_tb;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %0t got %h want %h", $time, a, e); end end
  logic        sys_clk, rstn, reg_wr, reg_rd, io_window_write;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, eeprom_load_data, tx_length;
  logic        eeprom_load_valid, eeprom_load_bus, eeprom_read_done;
  logic        eeprom_checksum_good, eeprom_small_size, eeprom_chip_select;
  logic        eeprom_data_in, init_complete, low_voltage_supply;
  logic        external_decode_present, sleep_pin, chip_reset_req;
  logic        suspend_reset, txrx_halt, sw_suspend_active;
  logic        hw_standby_active, hw_suspend_active, link_indicator;
  logic        bus_activity, link_indicator_pin, bus_activity_pin;
  logic        chip_select_n, io_read_cycle, mem_read_cycle;
  logic        dma_read_cycle, wait_request, memcs16_n, mem_mode_allowed;
  logic        ready_out, ready_oe, dma_active, rx_dma_abort;
  logic        dma_single_transfer, rx_buf_64k, dma_hold_off, irq_event;
  logic        irq_out, tx_cmd_valid, crc_append_inhibit, tx_space_avail;
  logic        tx_accept, tx_refuse, s_rst, s_abt, s_acc, s_ref;
  logic        s_sus;
  logic [7:0]  sa_high, mem_base;
  logic [15:0] d;
  int          bad_count, checks_done, n;

  csr_chip_self_bus u_dut (.*);
  csr_host_model u_host (.*);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Pulse outputs are caught here so short pulses are never missed
  always @(posedge sys_clk) begin
    if (chip_reset_req) s_rst <= 1'b1;
    if (rx_dma_abort) s_abt <= 1'b1;
    if (tx_accept) s_acc <= 1'b1;
    if (tx_refuse) s_ref <= 1'b1;
    if (suspend_reset) s_sus <= 1'b1;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_regs();
    u_host.rd(16'h0114, d); `CHK(d, 16'h0015)
    u_host.rd(16'h0116, d); `CHK(d, 16'h0017)
    u_host.rd(16'h0138, d); `CHK(d, 16'h0018)
    u_host.rd(16'h0118, d); `CHK(d, 16'h0000)
    u_host.wr(16'h0116, 16'hffbf);
    u_host.rd(16'h0116, d); `CHK(d, 16'hbf17)
    u_host.wr(16'h0136, 16'hffff);
    {low_voltage_supply, eeprom_chip_select, init_complete} = 3'b111;
    {eeprom_checksum_good, external_decode_present} = 2'b11;
    {eeprom_small_size, eeprom_read_done} = 2'b11;
    u_host.rd(16'h0136, d); `CHK(d, 16'h1dd6)
    eeprom_load_bus = 1'b1;
    eeprom_load_data = 16'h8000;
    eeprom_load_valid = 1'b1;
    cyc(1);
    eeprom_load_valid = 1'b0;
    u_host.rd(16'h0116, d); `CHK(d, 16'h8017)
  endtask
  task automatic t_pins();
    u_host.wr(16'h0114, 16'h0000);
    {link_indicator, bus_activity} = 2'b10;
    cyc(3); `CHK({link_indicator_pin, bus_activity_pin}, 2'b10)
    u_host.wr(16'h0114, 16'h3000);
    cyc(3); `CHK({link_indicator_pin, bus_activity_pin}, 2'b11)
    u_host.wr(16'h0114, 16'hf000);
    cyc(3); `CHK({link_indicator_pin, bus_activity_pin}, 2'b00)
    u_host.wr(16'h0114, 16'h0040);
    s_rst = 1'b0;
    cyc(4); `CHK(s_rst, 1'b1)
    u_host.rd(16'h0114, d); `CHK(d, 16'h0015)
    u_host.rd(16'h0116, d); `CHK(d, 16'h0017)
  endtask
  task automatic t_power();
    u_host.wr(16'h0114, 16'h0200);
    sleep_pin = 1'b0;
    cyc(6); `CHK({hw_standby_active, hw_suspend_active}, 2'b01)
    u_host.wr(16'h0114, 16'h0600);
    cyc(3); `CHK({hw_standby_active, hw_suspend_active}, 2'b10)
    sleep_pin = 1'b1;
    cyc(6); `CHK({hw_standby_active, hw_suspend_active}, 2'b00)
    sleep_pin = 1'b0;
    u_host.wr(16'h0114, 16'h0000);
    cyc(6); `CHK({hw_standby_active, hw_suspend_active}, 2'b00)
    sleep_pin = 1'b1;
    u_host.wr(16'h0116, 16'h8000);
    s_sus = 1'b0;
    u_host.wr(16'h0114, 16'h0100);
    cyc(2); `CHK({sw_suspend_active, txrx_halt}, 2'b11)
    `CHK(s_sus, 1'b1)
    u_host.rd(16'h0116, d); `CHK(d, 16'h0017)
    u_host.rd(16'h0114, d); `CHK(d, 16'h0115)
    u_host.wake();
    cyc(2); `CHK(sw_suspend_active, 1'b0)
  endtask
  task automatic t_tx();
    logic [17:0] tab [5];
    tab = '{{16'd1519,2'b11}, {16'd1515,2'b01}, {16'd1515,2'b10},
            {16'd1514,2'b00}, {16'd2,2'b00}};
    tx_space_avail = 1'b1;
    foreach (tab[i]) begin
      tx_length = tab[i][17:2];
      crc_append_inhibit = tab[i][1];
      {s_acc, s_ref} = 2'b00;
      tx_cmd_valid = 1'b1;
      cyc(1);
      tx_cmd_valid = 1'b0;
      cyc(2);
      `CHK({s_acc, s_ref}, (tab[i][0] || tab[i][17:2] < 16'd3) ? 2'b01 : 2'b10)
      u_host.rd(16'h0138, d);
      `CHK(d, {7'h00, !tab[i][0], tab[i][0], 7'h18})
    end
  endtask
  task automatic t_bus();
    u_host.wr(16'h0116, 16'h8000);
    irq_event = 1'b1;
    cyc(2); `CHK(irq_out, 1'b1)
    u_host.wr(16'h0116, 16'h0000);
    cyc(2); `CHK(irq_out, 1'b0)
    {io_read_cycle, wait_request} = 2'b11;
    cyc(2); `CHK(ready_oe, 1'b1)
    `CHK(ready_out, 1'b0)
    {io_read_cycle, dma_read_cycle} = 2'b01;
    cyc(2); `CHK(ready_oe, 1'b0)
    {io_read_cycle, dma_read_cycle} = 2'b10;
    u_host.wr(16'h0116, 16'h1000);
    cyc(2); `CHK(ready_oe, 1'b0)
    u_host.wr(16'h0116, 16'h0600);
    {sa_high, chip_select_n} = {8'h5a, 1'b0};
    cyc(5); `CHK({memcs16_n, mem_mode_allowed}, 2'b01)
    sa_high = 8'h00;
    cyc(5); `CHK(memcs16_n, 1'b1)
    u_host.wr(16'h0116, 16'h0000);
    cyc(5); `CHK({memcs16_n, mem_mode_allowed}, 2'b10)
    s_abt = 1'b0;
    u_host.wr(16'h0116, 16'h2940);
    cyc(2); `CHK({s_abt, dma_single_transfer, rx_buf_64k}, 3'b111)
    dma_active = 1'b1;
    for (n = 0; n < 1000 && !dma_hold_off; n++) cyc(1);
    `CHK(n >= 559 && n <= 561, 1'b1)
    for (n = 0; n < 100 && dma_hold_off; n++) cyc(1);
    `CHK(n >= 24 && n <= 26, 1'b1)
    dma_active = 1'b0;
  endtask
  initial begin
    {rstn, io_read_cycle, mem_read_cycle, dma_read_cycle} = 4'h0;
    {wait_request, dma_active, irq_event, tx_cmd_valid} = 4'h0;
    {eeprom_load_valid, eeprom_load_bus, eeprom_read_done} = 3'b000;
    {eeprom_checksum_good, eeprom_small_size, eeprom_chip_select} = 3'b000;
    {eeprom_data_in, init_complete, low_voltage_supply} = 3'b000;
    {external_decode_present, sleep_pin, link_indicator} = 3'b010;
    {bus_activity, chip_select_n, crc_append_inhibit} = 3'b010;
    {tx_space_avail, sa_high, mem_base} = {1'b0, 8'h00, 8'h5a};
    {eeprom_load_data, tx_length} = 32'h0000_0000;
    {bad_count, checks_done, s_rst, s_abt, s_acc, s_ref} = 0;
    s_sus = 1'b0;
    cyc(20);
    rstn = 1'b1;
    t_regs();
    t_pins();
    t_power();
    t_tx();
    t_bus();
    end_sim();
  end
  initial begin
    #1_000_000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
